// *** src/sync_serial_shift_unit.sv ***
// Clock-synchronous serial shift unit: 8/16-bit LSB-first send, receive or full duplex.
// Assumes one 40 MHz clock, a plain register port and an external serial peer on pins.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Any mode register write reinitialises state and enters serial start pending.
// - In start pending, shift-clock edges are ignored and nothing shifts.
// - Mode register read in start pending moves to transfer clock pending.
// - In clock pending, the first clock pulse starts counting, shifting, transfer state.
// - Continuous clock mode drives clock from clock pending, never enters transfer.
// - After 8 or 16 cycles, clear counter, return to clock pending.
// - Mode write during transfer clears counter and goes to start pending.
// - Every exit from transfer sets the interrupt flag as the counter clears.
// - Internal clock: start read starts the clock, stopping after 8 or 16 cycles.
// - After internal transfer no clock until next start; data-out holds last bit.
// - Between transfers, port register bit 7 sets the data-out level.
// - External clock: continued pulses after completion start a new word.
// - Start read during a transfer is an error and sets the interrupt flag.
// - Byte mode uses the lower register; halfword uses upper and lower.
// - Internal clock pulses are driven while transmit data shifts out.
// - Full duplex sends and samples simultaneously on the same clock.
// - Completion and error share one interrupt, gated by an enable bit.
// - Extra clock pulses show as flag set again by the mode write.
// - LSB first; send changes on falling edge, receive latches on rising edge.
// - Counter cleared by start read, counts from first fall, increments on rises.
module sync_serial_shift_unit (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe,
	input wire logic dataIn,
	output logic dataOut,
	output logic dataOutOe,
	output logic serialIrq
);

	sssu_pkg::sssu_regs_t r;
	sssu_pkg::sssu_regs_t next_r;

	logic sckSync;
	logic sckRise;
	logic sckFall;
	logic dinSync;

	sssu_pin_sync u_sck_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pinIn(sckIn),
		.level(sckSync),
		.rise(sckRise),
		.fall(sckFall)
	);

	sssu_pin_sync u_din_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pinIn(dataIn),
		.level(dinSync),
		.rise(),
		.fall()
	);

	// Half period of the internal shift clock in clk cycles
	function automatic logic [sssu_pkg::DIV_W-1:0] half_period(input logic [7:0] mode);
		half_period = sssu_pkg::DIV_ONE << mode[sssu_pkg::MODE_DIV_HI:sssu_pkg::MODE_DIV_LO];
	endfunction

	function automatic logic is_access(input logic strobe, input logic [2:0] a,
		input logic [2:0] target);
		is_access = strobe && (a == target);
	endfunction

	logic extClk;
	logic contMode;
	logic [4:0] wordBits;
	logic shFall;
	logic shRise;
	logic setFlag;
	logic rxBit;
	logic [sssu_pkg::DIV_W-1:0] halfCount;

	always_comb begin
		next_r = r;
		setFlag = 1'b0;
		shFall = 1'b0;
		shRise = 1'b0;
		extClk = r.mode[sssu_pkg::MODE_EXT_BIT];
		contMode = (r.mode[sssu_pkg::MODE_EN_HI:sssu_pkg::MODE_EN_LO] == 2'b00) && !extClk;
		wordBits = r.mode[sssu_pkg::MODE_WIDTH_BIT] ? sssu_pkg::HALF_BITS
			: sssu_pkg::BYTE_BITS;
		halfCount = half_period(r.mode) - sssu_pkg::DIV_ONE;
		rxBit = r.pinSel[sssu_pkg::PIN_IN_BIT] ? dinSync : 1'b1;
		next_r.rdData = sssu_pkg::READ_IDLE;

		// Shift clock source: internal divider or synchronised pin
		if (extClk) begin
			shFall = sckFall && r.pinSel[sssu_pkg::PIN_CLK_BIT];
			shRise = sckRise && r.pinSel[sssu_pkg::PIN_CLK_BIT];
		end else if (r.runClk) begin
			if (r.divCount == '0) begin
				next_r.divCount = halfCount;
				next_r.sckLevel = !r.sckLevel;
				shFall = r.sckLevel;
				shRise = !r.sckLevel;
			end else begin
				next_r.divCount = r.divCount - sssu_pkg::DIV_ONE;
			end
		end

		// Controller
		case (r.state)
			sssu_pkg::ST_START_PEND: begin
				// Clock edges have no effect here
				next_r.bitCount = '0;
			end
			sssu_pkg::ST_CLK_PEND: begin
				if (shFall && !contMode) begin
					next_r.state = sssu_pkg::ST_XFER;
					next_r.outBit = r.lower[0];
				end
			end
			sssu_pkg::ST_XFER: begin
				if (shFall) begin
					next_r.outBit = r.lower[0];
				end
				if (shRise) begin
					// Received bit enters at the top of the active word
					if (r.mode[sssu_pkg::MODE_WIDTH_BIT]) begin
						next_r.upper = {rxBit, r.upper[7:1]};
						next_r.lower = {r.upper[0], r.lower[7:1]};
					end else begin
						next_r.lower = {rxBit, r.lower[7:1]};
					end
					if (r.bitCount + 5'h01 == wordBits) begin
						next_r.bitCount = '0;
						next_r.state = sssu_pkg::ST_CLK_PEND;
						setFlag = 1'b1;
						if (!extClk) begin
							next_r.runClk = 1'b0;
						end
					end else begin
						next_r.bitCount = r.bitCount + 5'h01;
					end
				end
			end
			default: begin
				next_r.state = sssu_pkg::ST_START_PEND;
			end
		endcase

		// Mode register read: start or error
		if (is_access(rdStrobe, addr, sssu_pkg::ADDR_MODE)) begin
			next_r.bitCount = '0;
			if (r.state == sssu_pkg::ST_START_PEND) begin
				next_r.state = sssu_pkg::ST_CLK_PEND;
				next_r.runClk = !extClk;
				next_r.sckLevel = 1'b1;
				next_r.divCount = halfCount;
			end else if (r.state == sssu_pkg::ST_XFER) begin
				next_r.state = sssu_pkg::ST_CLK_PEND;
				next_r.runClk = 1'b0;
				next_r.sckLevel = 1'b1;
				setFlag = 1'b1;
			end
		end

		// Register writes
		if (wrStrobe) begin
			case (addr)
				sssu_pkg::ADDR_MODE: begin
					next_r.mode = wrData;
					next_r.state = sssu_pkg::ST_START_PEND;
					next_r.bitCount = '0;
					next_r.runClk = 1'b0;
					next_r.sckLevel = 1'b1;
					next_r.divCount = '0;
					if (r.state == sssu_pkg::ST_XFER) begin
						setFlag = 1'b1;
					end
				end
				sssu_pkg::ADDR_LOWER: begin
					next_r.lower = wrData;
				end
				sssu_pkg::ADDR_UPPER: begin
					next_r.upper = wrData;
				end
				sssu_pkg::ADDR_PORT: begin
					if (r.state != sssu_pkg::ST_XFER) begin
						next_r.outBit = wrData[sssu_pkg::PORT_IDLE_BIT];
					end
				end
				sssu_pkg::ADDR_IRQ: begin
					next_r.irqFlag = wrData[sssu_pkg::IRQ_FLAG_BIT];
					next_r.irqEnable = wrData[sssu_pkg::IRQ_EN_BIT];
				end
				sssu_pkg::ADDR_PINSEL: begin
					next_r.pinSel = wrData[3:0];
				end
				default: begin
				end
			endcase
		end

		// Hardware set wins over a software clear in the same cycle
		if (setFlag) begin
			next_r.irqFlag = 1'b1;
		end

		// Read data appear in the following cycle only
		if (rdStrobe) begin
			case (addr)
				sssu_pkg::ADDR_MODE: begin
					next_r.rdData = r.mode;
				end
				sssu_pkg::ADDR_LOWER: begin
					next_r.rdData = r.lower;
				end
				sssu_pkg::ADDR_UPPER: begin
					next_r.rdData = r.upper;
				end
				sssu_pkg::ADDR_PORT: begin
					next_r.rdData = {r.outBit, 1'b0, r.bitCount, sckSync};
				end
				sssu_pkg::ADDR_IRQ: begin
					next_r.rdData = {4'h0, r.state, r.irqEnable, r.irqFlag};
				end
				sssu_pkg::ADDR_PINSEL: begin
					next_r.rdData = {4'h0, r.pinSel};
				end
				default: begin
					next_r.rdData = sssu_pkg::READ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r.state <= sssu_pkg::ST_START_PEND;
			r.bitCount <= '0;
			r.mode <= sssu_pkg::MODE_RESET;
			r.lower <= sssu_pkg::DATA_RESET;
			r.upper <= sssu_pkg::DATA_RESET;
			r.pinSel <= sssu_pkg::PINSEL_RESET;
			r.outBit <= 1'b1;
			r.irqFlag <= 1'b0;
			r.irqEnable <= 1'b0;
			r.runClk <= 1'b0;
			r.sckLevel <= 1'b1;
			r.divCount <= '0;
			r.rdData <= sssu_pkg::READ_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign rdData = r.rdData;
	assign sckOut = r.sckLevel;
	assign sckOe = r.pinSel[sssu_pkg::PIN_CLK_BIT] && !r.mode[sssu_pkg::MODE_EXT_BIT];
	assign dataOut = r.outBit;
	// Open-drain drives only the low level
	assign dataOutOe = r.pinSel[sssu_pkg::PIN_OUT_BIT]
		&& (!r.pinSel[sssu_pkg::PIN_OD_BIT] || !r.outBit);
	assign serialIrq = r.irqFlag && r.irqEnable;

endmodule // sync_serial_shift_unit

`default_nettype wire

// *** include/sssu_pkg.sv ***
// Package for the clock-synchronous serial shift unit: register map, field positions,
// reset values, controller states and the packed state records of both modules.
// Assumes a single 40 MHz clock and an 8-bit register port.
package sssu_pkg;

	// Register indices on the plain register port
	localparam logic [2:0] ADDR_MODE = 3'h0;
	localparam logic [2:0] ADDR_LOWER = 3'h1;
	localparam logic [2:0] ADDR_UPPER = 3'h2;
	localparam logic [2:0] ADDR_PORT = 3'h3;
	localparam logic [2:0] ADDR_IRQ = 3'h4;
	localparam logic [2:0] ADDR_PINSEL = 3'h5;

	// serial_mode_reg fields
	localparam int MODE_WIDTH_BIT = 6;
	localparam int MODE_EN_HI = 5;
	localparam int MODE_EN_LO = 4;
	localparam int MODE_EXT_BIT = 3;
	localparam int MODE_DIV_HI = 2;
	localparam int MODE_DIV_LO = 0;

	// serial_port_reg, interrupt and pin-function fields
	localparam int PORT_IDLE_BIT = 7;
	localparam int IRQ_FLAG_BIT = 0;
	localparam int IRQ_EN_BIT = 1;
	localparam int PIN_OUT_BIT = 3;
	localparam int PIN_IN_BIT = 2;
	localparam int PIN_CLK_BIT = 1;
	localparam int PIN_OD_BIT = 0;

	// Reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [3:0] PINSEL_RESET = 4'h0;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// Word lengths and internal clock divider
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam logic [4:0] HALF_BITS = 5'h10;
	localparam int DIV_W = 8;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;

	typedef enum logic [1:0] {
		ST_START_PEND,
		ST_CLK_PEND,
		ST_XFER
	} sssu_state_t;

	typedef struct packed {
		sssu_state_t state;
		logic [4:0] bitCount;
		logic [7:0] mode;
		logic [7:0] lower;
		logic [7:0] upper;
		logic [3:0] pinSel;
		logic outBit;
		logic irqFlag;
		logic irqEnable;
		logic runClk;
		logic sckLevel;
		logic [DIV_W-1:0] divCount;
		logic [7:0] rdData;
	} sssu_regs_t;

	typedef struct packed {
		logic stage1;
		logic stage2;
		logic prev;
	} sssu_sync_t;

endpackage

// *** src/sssu_pin_sync.sv ***
// Two-flop synchroniser for one pin, with edge pulses taken after the second flop.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none

module sssu_pin_sync (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pinIn,
	output logic level,
	output logic rise,
	output logic fall
);

	sssu_pkg::sssu_sync_t r;
	sssu_pkg::sssu_sync_t next_r;

	always_comb begin
		next_r.stage1 = pinIn;
		next_r.stage2 = r.stage1;
		next_r.prev = r.stage2;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// Idle-high reset level, so no false rise follows reset on the clock pin
			r <= '1;
		end else begin
			r <= next_r;
		end
	end

	assign level = r.stage2;
	assign rise = r.stage2 & ~r.prev;
	assign fall = ~r.stage2 & r.prev;

endmodule // sssu_pin_sync

`default_nettype wire

// *** test/sssu_monitor.sv ***
// Checker on the ports of the serial shift unit, bound after the module.
// Assumes the register index map of the unit's package and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module sssu_monitor (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire logic [7:0] rdData,
	input wire logic sckIn,
	input wire logic sckOut,
	input wire logic sckOe,
	input wire logic dataIn,
	input wire logic dataOut,
	input wire logic dataOutOe,
	input wire logic serialIrq
);
	logic pend;
	logic [7:0] lastMode;
	wire logic modeWr = wrStrobe && addr == sssu_pkg::ADDR_MODE;
	wire logic irqWr = wrStrobe && addr == sssu_pkg::ADDR_IRQ;
	// Start pending: entered by a mode write, left by a mode read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// The unit leaves reset in start pending
			pend <= 1'b1;
			lastMode <= sssu_pkg::MODE_RESET;
		end else begin
			pend <= modeWr || (pend && !(rdStrobe && addr == sssu_pkg::ADDR_MODE));
			lastMode <= modeWr ? wrData : lastMode;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_pendClk; pend && $past(pend) |-> sckOut; endproperty
	a_pendClk: assert property (p_pendClk) else $error("clock moved in start pending");
	property p_pendData; pend && $past(pend) && !wrStrobe && !$past(wrStrobe) |=> $stable(dataOut); endproperty
	a_pendData: assert property (p_pendData) else $error("data out moved in start pending");
	property p_portWr;
		modeWr ##1 (wrStrobe && addr == sssu_pkg::ADDR_PORT) |=> ##1 dataOut == $past(wrData[7], 2);
	endproperty
	a_portWr: assert property (p_portWr) else $error("port write did not set data out");
	property p_rdMode; rdStrobe && addr == sssu_pkg::ADDR_MODE |=> rdData == lastMode; endproperty
	a_rdMode: assert property (p_rdMode) else $error("mode read returned wrong value");
	property p_irqOn; irqWr && wrData[1:0] == 2'b11 |=> serialIrq; endproperty
	a_irqOn: assert property (p_irqOn) else $error("enabled flag gave no interrupt");
	property p_irqOff; irqWr && !wrData[1] |=> !serialIrq; endproperty
	a_irqOff: assert property (p_irqOff) else $error("masked flag gave interrupt");
	property p_irqHold; serialIrq && !wrStrobe |=> serialIrq; endproperty
	a_irqHold: assert property (p_irqHold) else $error("interrupt dropped by itself");
	// A flag raised by software is not the end of a transfer
	property p_stopHigh; $rose(serialIrq) && !$past(irqWr) |-> sckOut [*4]; endproperty
	a_stopHigh: assert property (p_stopHigh) else $error("clock not stopped high");
	c_done: cover property ($rose(serialIrq));
	c_start: cover property (pend ##1 !pend);
	c_clk: cover property ($fell(sckOut));
endmodule // sssu_monitor
bind sync_serial_shift_unit sssu_monitor sssu_monitor_i (.clk(clk), .reset_n(reset_n),
	.addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
	.sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .dataIn(dataIn), .dataOut(dataOut),
	.dataOutOe(dataOutOe), .serialIrq(serialIrq));
`default_nettype wire

// *** test/sssu_peer.sv ***
// Behavioural serial peer: clocks the unit or follows its clock, LSB first.
// Assumes the bench resolves the shared clock pin and pulls the data line up.
`timescale 1ns/10ps
`default_nettype none
module sssu_peer (
	input wire logic sckLine,
	input wire logic dataLine,
	output logic sckDrv,
	output logic dataIn
);
	logic [15:0] rxWord;
	initial begin
		sckDrv = 1'b1;
		dataIn = 1'b0;
		rxWord = 16'h0000;
	end
	// Own clock idles high outside frames, 200 ns period inside
	task automatic frame(input logic [15:0] txWord, input int bits, input logic ext);
		// Start off the bench clock edge
		#5;
		for (int i = 0; i < bits; i++) begin
			if (ext) sckDrv = 1'b0;
			else @(negedge sckLine);
			dataIn = txWord[i];
			if (ext) #100 sckDrv = 1'b1;
			else @(posedge sckLine);
			rxWord = {dataLine, rxWord[15:1]};
			if (ext) #100;
		end
		// A released line must not look held
		dataIn = ~dataIn;
	endtask
endmodule // sssu_peer
`default_nettype wire

// *** test/sync_serial_shift_unit_tb_top.sv ***
// Self-checking bench for the serial shift unit with a serial peer model.
// Assumes the package, the unit, its checker and the peer are compiled first.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_shift_unit_tb_top;
	localparam logic [2:0] aMode = sssu_pkg::ADDR_MODE;
	localparam logic [2:0] aLow = sssu_pkg::ADDR_LOWER;
	localparam logic [2:0] aUp = sssu_pkg::ADDR_UPPER;
	localparam logic [2:0] aIrq = sssu_pkg::ADDR_IRQ;
	logic clk, reset_n, wrStrobe, rdStrobe, sckOut, sckOe, dataOut, dataOutOe, serialIrq;
	logic sckDrv, dataIn, sckLine, dataLine;
	logic [2:0] addr;
	logic [7:0] wrData, rdData;
	int errors = 0;
	int total_checks = 0;
	assign sckLine = sckOe ? sckOut : sckDrv;
	assign dataLine = dataOutOe ? dataOut : 1'b1;
	sync_serial_shift_unit sync_serial_shift_unit_i (.clk(clk), .reset_n(reset_n), .addr(addr),
		.wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
		.sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe), .dataIn(dataIn), .dataOut(dataOut),
		.dataOutOe(dataOutOe), .serialIrq(serialIrq));
	sssu_peer sssu_peer_i (.sckLine(sckLine), .dataLine(dataLine), .sckDrv(sckDrv), .dataIn(dataIn));
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
		wrStrobe <= w;
		rdStrobe <= r;
		addr <= a;
		wrData <= d;
		@(posedge clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic idle;
		bus(1'b0, 1'b0, aMode, 8'h00);
		#1;
	endtask
	task automatic rdChk(input string what, input logic [2:0] a, input logic [7:0] exp);
		bus(1'b0, 1'b1, a, 8'h00);
		#1 chk(what, {8'h00, exp}, {8'h00, rdData});
		bus(1'b0, 1'b0, a, 8'h00);
	endtask
	task automatic waitIrq;
		for (int i = 0; i < 400 && serialIrq !== 1'b1; i++) @(posedge clk);
		#1 chk("serialIrq", 16'h0001, 16'(serialIrq));
	endtask
	task automatic testReset;
		chk("sckOut", 16'h0001, 16'(sckOut));
		wr(aIrq, 8'h03);
		idle();
		chk("irqOn", 16'h0001, 16'(serialIrq));
		wr(aIrq, 8'h01);
		idle();
		chk("irqMasked", 16'h0000, 16'(serialIrq));
		rdChk("mode", aMode, sssu_pkg::MODE_RESET);
		rdChk("unmapped", 3'h7, sssu_pkg::READ_IDLE);
	endtask
	task automatic testByteInt;
		wr(sssu_pkg::ADDR_PINSEL, 8'h0E);
		wr(aIrq, 8'h02);
		wr(aMode, 8'h12);
		wr(aLow, 8'h25);
		rdChk("start", aMode, 8'h12);
		sssu_peer_i.frame(16'h003C, 8, 1'b0);
		waitIrq();
		chk("peerRx", 16'h0025, 16'(sssu_peer_i.rxWord[15:8]));
		rdChk("rxLow", aLow, 8'h3C);
		rdChk("irqState", aIrq, 8'h07);
		repeat (20) @(posedge clk);
		#1 chk("clkIdle", 16'h0001, 16'(sckOut));
		chk("lastBit", 16'h0000, 16'(dataOut));
	endtask
	task automatic testHalfExt;
		wr(aMode, 8'h5A);
		wr(aUp, 8'h12);
		wr(aLow, 8'h34);
		wr(aIrq, 8'h02);
		rdChk("start", aMode, 8'h5A);
		sssu_peer_i.frame(16'hBEEF, 16, 1'b1);
		waitIrq();
		chk("peerRx", 16'h1234, sssu_peer_i.rxWord);
		rdChk("rxUp", aUp, 8'hBE);
		rdChk("rxLow", aLow, 8'hEF);
		wr(aIrq, 8'h02);
		wr(sssu_pkg::ADDR_PINSEL, 8'h0A);
		idle();
		chk("extClkOe", 16'h0000, 16'(sckOe));
		sssu_peer_i.frame(16'h0000, 1, 1'b1);
		rdChk("resumed", aIrq, 8'h0A);
		rdChk("portState", sssu_pkg::ADDR_PORT, 8'h83);
		wr(aMode, 8'h5A);
		idle();
		chk("extraPulse", 16'h0001, 16'(serialIrq));
		rdChk("aborted", aIrq, 8'h03);
		rdChk("forcedIn", aUp, 8'hDF);
		rdChk("resumedShift", aLow, 8'h77);
	endtask
	task automatic testPendErr;
		wr(aMode, 8'h5A);
		wr(aLow, 8'h5C);
		wr(aIrq, 8'h02);
		idle();
		sssu_peer_i.frame(16'h00FF, 8, 1'b1);
		rdChk("ignored", aIrq, 8'h02);
		rdChk("noShift", aLow, 8'h5C);
		rdChk("start", aMode, 8'h5A);
		sssu_peer_i.frame(16'h0000, 3, 1'b1);
		rdChk("errRead", aMode, 8'h5A);
		rdChk("errState", aIrq, 8'h07);
	endtask
	task automatic testContPort;
		int edges = 0;
		logic last;
		wr(aIrq, 8'h02);
		wr(aMode, 8'h02);
		wr(sssu_pkg::ADDR_PORT, 8'h00);
		idle();
		chk("portLevel", 16'h0000, 16'(dataOut));
		rdChk("start", aMode, 8'h02);
		#1 last = sckOut;
		repeat (40) begin
			@(posedge clk);
			#1 if (sckOut !== last) edges++;
			last = sckOut;
		end
		chk("clkEdges", 16'h000A, 16'(edges));
		rdChk("noXfer", aIrq, 8'h06);
		chk("noShift", 16'h0000, 16'(dataOut));
		chk("clkOe", 16'h0001, 16'(sckOe));
		chk("dataOe", 16'h0001, 16'(dataOutOe));
		wr(sssu_pkg::ADDR_PINSEL, 8'h0F);
		wr(sssu_pkg::ADDR_PORT, 8'h80);
		idle();
		chk("openDrain", 16'h0000, 16'(dataOutOe));
		chk("portHigh", 16'h0001, 16'(dataOut));
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		reset_n = 1'b0;
		addr = 3'h0;
		wrData = 8'h00;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		testReset();
		testByteInt();
		testHalfExt();
		testPendErr();
		testContPort();
		complete_run();
	end
	initial begin
		#200000;
		errors++;
		complete_run();
	end
endmodule // sync_serial_shift_unit_tb_top
`default_nettype wire
